// ---- bench/boot_host_model.sv ----
// Boot controller model on the far side of the loader's UART link
`timescale 1ns/1ps
module boot_host_model (
  // Clocking
  input wire logic clk_sys_i,
  // Serial link
  input wire logic txd_i,
  output logic rxd_o
);
  int bit_cyc = 16;
  initial rxd_o = 1'b1;

  // Bad stop is cut short so the line idles high before the next start
  task automatic send_byte(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < bit_cyc; c++) begin
        @(posedge clk_sys_i);
        rxd_o <= (i == 9 && c < 3 * bit_cyc / 4) ? ~bad : f[i]; // LSB first at chosen rate
      end
    end
  endtask : send_byte

  task automatic send_seg(input logic [7:0] q[$], input int err, input logic [7:0] adj);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) begin
      send_byte(q[i], i == err);
      s = s + q[i];
    end
    send_byte(8'h00 - s + adj, 1'b0); // Two's complement trailer
  endtask : send_seg

  // Reply wait is bounded, scaled down from seconds
  task automatic recv_byte(output logic [7:0] b, output logic got);
    int n;
    b = 8'hxx;
    got = 1'b0;
    n = 0;
    while (txd_i !== 1'b0 && n < 4000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (txd_i === 1'b0) begin
      repeat (bit_cyc / 2) @(posedge clk_sys_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk_sys_i);
        b[i] = txd_i;
      end
      repeat (bit_cyc) @(posedge clk_sys_i);
      got = txd_i;
      repeat (bit_cyc) @(posedge clk_sys_i);
    end
  endtask : recv_byte
endmodule : boot_host_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the serial boot RAM loader
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam logic [95:0] PW = 96'h5a3c_e1f0_0f96_a5c3_7e18_d24b;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd_prot = 1'b0;
  logic wr_prot = 1'b0;
  logic ram_rdy = 1'b0;
  logic stall = 1'b0;
  logic rxd, txd, prot_set, we, halted, rx_en, go;
  logic [31:0] ram_addr, exec_addr, exec_seen;
  logic [15:0] baud;
  logic [7:0] ram_wdata;
  logic [31:0] wr_addr[$];
  logic [7:0] wr_data[$], q[$];
  int n_mismatch = 0;
  int check_count = 0;
  int n_exec = 0;
  int n_prot = 0;

  serial_boot_ram_loader #(.FIFO_DEPTH(32)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
    .rxd_i(rxd), .txd_o(txd), .pw_ref_i(PW), .read_prot_i(rd_prot), .write_prot_i(wr_prot),
    .protect_set_o(prot_set), .ram_we_o(we), .ram_ready_i(ram_rdy), .ram_addr_o(ram_addr),
    .ram_wdata_o(ram_wdata), .boot_halted_o(halted), .receiver_enable_bit_o(rx_en),
    .baud_gen_ctrl_o(baud), .exec_start_o(go), .exec_addr_o(exec_addr));
  boot_host_model host (.clk_sys_i(clk_sys_i), .txd_i(txd), .rxd_o(rxd));

  initial forever #5 clk_sys_i = ~clk_sys_i;

  // RAM side stalls on request and logs every accepted write
  always @(posedge clk_sys_i) begin
    ram_rdy <= ~stall;
    if (we === 1'b1 && ram_rdy === 1'b1) begin
      wr_addr.push_back(ram_addr);
      wr_data.push_back(ram_wdata);
    end
    if (go === 1'b1) begin
      n_exec++;
      exec_seen = exec_addr;
    end
    if (prot_set === 1'b1) n_prot++;
  end

  task automatic ack(input logic [7:0] e);
    logic [7:0] b;
    logic got;
    host.recv_byte(b, got);
    `CHK({got, b}, {1'b1, e})
  endtask : ack

  task automatic pw_phase(input logic [7:0] cmd, input int err, input logic [7:0] adj, input int flip,
                          input logic [7:0] e);
    host.send_byte(cmd, 1'b0);
    ack(cmd);
    q = {};
    for (int i = 0; i < 12; i++) q.push_back(PW[95-8*i -: 8] ^ {7'h00, i == flip});
    host.send_seg(q, err, adj);
    ack(e);
  endtask : pw_phase

  task automatic payload(input logic [31:0] base, input int len, input logic hbad, input logic [7:0] adj,
                         input int hold, input logic [7:0] e);
    pw_phase(8'h10, -1, 8'h00, -1, 8'h10);
    q = {base[31:24], base[23:16], base[15:8], base[7:0], len[15:8], len[7:0]};
    host.send_seg(q, -1, {7'h00, hbad});
    ack(hbad ? 8'h11 : 8'h10);
    if (hbad) return;
    q = {};
    for (int i = 0; i < len; i++) q.push_back(8'(i * 37 + 5));
    wr_addr = {};
    wr_data = {};
    @(posedge clk_sys_i);
    stall <= 1'b1;
    fork
      host.send_seg(q, -1, adj);
      begin
        repeat (hold) @(posedge clk_sys_i);
        stall <= 1'b0;
      end
    join
    `CHK(n_exec, 0)
    ack(e);
  endtask : payload

  task automatic t_sync;
    `CHK({txd, rx_en, baud}, {1'b1, 1'b0, 16'h0000})
    host.send_byte(8'h86, 1'b0);
    ack(8'h86);
    `CHK({rx_en, halted, baud}, {1'b1, 1'b0, 16'h0010})
    $display("test sync done");
  endtask : t_sync

  task automatic t_cmd;
    host.send_byte(8'h10, 1'b1);
    ack(8'h08);
    host.send_byte(8'h35, 1'b0);
    ack(8'h01);
    host.send_byte(8'h77, 1'b1);
    ack(8'h38);
    host.send_byte(8'h1f, 1'b0);
    ack(8'h31);
    for (int k = 1; k < 3; k++) begin
      @(posedge clk_sys_i);
      rd_prot <= k[0];
      wr_prot <= k[1];
      host.send_byte(8'h10, 1'b0);
      ack(8'h16);
    end
    @(posedge clk_sys_i);
    rd_prot <= 1'b0;
    wr_prot <= 1'b0;
    $display("test command refusals done");
  endtask : t_cmd

  task automatic t_pw;
    pw_phase(8'h10, -1, 8'h01, -1, 8'h11);
    pw_phase(8'h10, -1, 8'h00, 0, 8'h11);
    pw_phase(8'h10, 5, 8'h01, -1, 8'h18);
    $display("test password refusals done");
  endtask : t_pw

  task automatic t_prot;
    pw_phase(8'h60, -1, 8'h00, 3, 8'h61);
    `CHK(n_prot, 0)
    pw_phase(8'h60, -1, 8'h00, -1, 8'h60);
    repeat (4) @(posedge clk_sys_i);
    `CHK(n_prot, 1)
    $display("test protect set done");
  endtask : t_prot

  // Overflow run releases the stall during the checksum byte
  task automatic t_load;
    payload(32'h0000_1000, 8, 1'b1, 8'h00, 1, 8'h11);
    payload(32'h0000_1000, 4, 1'b0, 8'h01, 1, 8'h11);
    payload(32'h0000_1000, 34, 1'b0, 8'h00, 5480, 8'h18);
    payload(32'h0000_1200, 40, 1'b0, 8'h00, 3200, 8'h10);
    repeat (4) @(posedge clk_sys_i);
    `CHK({n_exec[7:0], exec_seen}, {8'h01, 32'h0000_1200})
    `CHK(wr_addr.size(), 40)
    foreach (wr_addr[i]) begin
      `CHK({wr_addr[i], wr_data[i]}, {32'h0000_1200 + i, q[i]})
    end
    $display("test ram load done");
  endtask : t_load

  task automatic t_halt;
    logic [7:0] b;
    logic got;
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    host.bit_cyc = 2;
    host.send_byte(8'h86, 1'b0);
    host.bit_cyc = 16;
    host.recv_byte(b, got);
    `CHK({got, halted, rx_en}, 3'b010)
    $display("test rate halt done");
  endtask : t_halt

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_sync();
    t_cmd();
    t_pw();
    t_prot();
    t_load();
    t_halt();
    final_report();
  end

  // Tests need about 48k cycles
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    n_mismatch++;
    final_report();
  end
endmodule : tb_top

// ---- src/boot_loader_pkg.sv ----
// Package: constants and state codes of the serial boot RAM loader
// How it works
// RULE_01 - Controller opens with 86H; receiver off, device times it to find the bit period.
// RULE_02 - Bit period out of range: device halts and never transmits anything.
// RULE_03 - Good rate: load baud setting, enable receiver, then send 86H acknowledge.
// RULE_04 - Controller gives up after 5 seconds without a proper 86H reply.
// RULE_05 - Third byte carries the command; 10H asks for a RAM transfer.
// RULE_06 - Command byte with receive error answers previous upper nibble with 8.
// RULE_07 - RAM transfer command without protection is echoed 10H and proceeds.
// RULE_08 - Protection active: command answered with low nibble 6, then new command awaited.
// RULE_09 - Unknown command answered with low nibble 1, then new command awaited.
// RULE_10 - Twelve password bytes compared in order with stored flash password.
// RULE_11 - Each segment ends with two's complement checksum of its bytes.
// RULE_12 - Receive error in password segment answers 18H, back to command wait.
// RULE_13 - Password segment sum nonzero answers 11H, back to command wait.
// RULE_14 - Any password mismatch answers 11H, back to command wait.
// RULE_15 - Password segment fully good answers 10H.
// RULE_16 - Four address bytes arrive most significant first.
// RULE_17 - Two length bytes arrive high byte first.
// RULE_18 - Header segment: receive error answers 18H, bad sum answers 11H.
// RULE_19 - Controller keeps loaded data inside internal user RAM window.
// RULE_20 - Payload bytes stored at consecutive addresses from start, exactly length bytes.
// RULE_21 - Payload: receive error 18H, bad sum 11H, otherwise 10H.
// RULE_22 - Execution starts at start address only after payload answered 10H.
// RULE_23 - Protect Set enables read and write protection, skipped on password failure.
// RULE_24 - All password bytes are received; mismatch remembered until checksum arrives.
package boot_loader_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BIT_W = 16;
  localparam logic [BIT_W-1:0] MIN_BIT_CYC = 16'h0004;
  localparam logic [BIT_W-1:0] BAUD_RST = 16'h0000;
  localparam logic [2:0] IDLE_BITS = 3'h4;
  localparam logic [7:0] SYNC_BYTE = 8'h86;
  localparam logic [7:0] CMD_RAM = 8'h10;
  localparam logic [7:0] CMD_PROT = 8'h60;
  localparam logic [3:0] NIB_OK = 4'h0;
  localparam logic [3:0] NIB_SUM = 4'h1;
  localparam logic [3:0] NIB_PROT = 4'h6;
  localparam logic [3:0] NIB_COMM = 4'h8;
  localparam logic [3:0] CMD_HI_RST = 4'h0;
  localparam int PW_BYTES = 12;
  localparam logic [3:0] PW_LAST = 4'hc;
  localparam logic [3:0] HDR_LAST = 4'h6;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W = 32;
  localparam int LEN_W = 16;

  typedef enum logic [3:0] {
    S_MEAS_WAIT = 4'h0,
    S_MEAS_LOW = 4'h1,
    S_MEAS_IDLE = 4'h2,
    S_HALT = 4'h3,
    S_ACK = 4'h4,
    S_CMD = 4'h5,
    S_PW = 4'h6,
    S_HDR = 4'h7,
    S_DATA = 4'h8,
    S_DCHK = 4'h9,
    S_DRAIN = 4'ha,
    S_RUN = 4'hb
  } state_t;
endpackage : boot_loader_pkg

// ---- src/byte_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clocking
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// ---- src/serial_boot_ram_loader.sv ----
// Serial boot command handler: rate detect, RAM transfer, protect set
`timescale 1ns/1ps
module serial_boot_ram_loader #(
  parameter int FIFO_DEPTH = boot_loader_pkg::FIFO_DEPTH
) (
  // Clocking
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial pins
  input wire logic rxd_i,
  output logic txd_o,
  // Flash password and protection state
  input wire logic [8*boot_loader_pkg::PW_BYTES-1:0] pw_ref_i,
  input wire logic read_prot_i,
  input wire logic write_prot_i,
  output logic protect_set_o,
  // RAM write port
  output logic ram_we_o,
  input wire logic ram_ready_i,
  output logic [boot_loader_pkg::ADDR_W-1:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  // Status and hand-off
  output logic boot_halted_o,
  output logic receiver_enable_bit_o,
  output logic [boot_loader_pkg::BIT_W-1:0] baud_gen_ctrl_o,
  output logic exec_start_o,
  output logic [boot_loader_pkg::ADDR_W-1:0] exec_addr_o
);
  localparam int BW = boot_loader_pkg::BIT_W;

  // Ack code by priority: receive error, then checksum, then password
  function automatic logic [7:0] ack_code(input logic [3:0] hi, input logic e, input logic [7:0] s,
                                          input logic bad);
    if (e) ack_code = {hi, boot_loader_pkg::NIB_COMM};
    else if (s != 8'h00 || bad) ack_code = {hi, boot_loader_pkg::NIB_SUM};
    else ack_code = {hi, boot_loader_pkg::NIB_OK};
  endfunction : ack_code

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic rx_m_q;
  logic rx_s_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else if (ce_i) begin
      rx_m_q <= rxd_i;
      rx_s_q <= rx_m_q;
    end
  end

  // ****************************************
  // Receiver and transmitter
  // ****************************************
  logic rx_en_q;
  logic [BW-1:0] baud_q;
  logic rx_busy_q;
  logic [BW-1:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_vld_q;
  logic rx_err_q;
  logic tx_busy_q;
  logic [9:0] tx_sh_q;
  logic [BW-1:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic tx_go;
  logic [7:0] ack_q;

  wire rx_tick = (rx_cnt_q == '0);
  wire tx_tick = (tx_cnt_q == '0);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_vld_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else if (ce_i) begin
      rx_vld_q <= 1'b0;
      if (!rx_en_q) begin
        rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
        if (!rx_s_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= baud_q >> 1;
          rx_bit_q <= '0;
        end
      end else if (!rx_tick) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= baud_q - 1'b1;
        rx_bit_q <= rx_bit_q + 1'b1;
        if (rx_bit_q == 4'h0 && rx_s_q) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_vld_q <= 1'b1;
          rx_err_q <= !rx_s_q;
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3ff;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
    end else if (ce_i) begin
      if (tx_go) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, ack_q, 1'b0};
        tx_cnt_q <= baud_q - 1'b1;
        tx_bit_q <= '0;
      end else if (tx_busy_q && !tx_tick) begin
        tx_cnt_q <= tx_cnt_q - 1'b1;
      end else if (tx_busy_q) begin
        tx_cnt_q <= baud_q - 1'b1;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 1'b1;
        tx_busy_q <= (tx_bit_q != 4'h9);
      end
    end
  end
  assign txd_o = tx_sh_q[0];

  // ****************************************
  // Payload buffer
  // ****************************************
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_sh_q),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(ram_ready_i),
    .out_data_o(ram_wdata_o)
  );
  assign ram_we_o = fifo_out_valid;

  // ****************************************
  // Session sequencer
  // ****************************************
  boot_loader_pkg::state_t st_q;
  boot_loader_pkg::state_t ret_q;
  logic [BW:0] meas_q;
  logic sent_q;
  logic [3:0] cmd_hi_q;
  logic cmd_prot_q;
  logic [3:0] idx_q;
  logic [7:0] sum_q;
  logic err_q;
  logic pw_bad_q;
  logic [boot_loader_pkg::ADDR_W-1:0] addr_q;
  logic [boot_loader_pkg::LEN_W-1:0] len_q;
  logic [boot_loader_pkg::ADDR_W-1:0] wr_addr_q;
  logic prot_q;
  logic exec_q;

  wire [7:0] sum_now = sum_q + rx_sh_q;
  wire err_now = err_q || rx_err_q;
  wire [7:0] pw_byte = pw_ref_i[8*(boot_loader_pkg::PW_BYTES-1-int'(idx_q)) +: 8];
  wire protected_now = read_prot_i || write_prot_i;
  wire [7:0] seg_ack = ack_code(cmd_hi_q, err_now, sum_now, pw_bad_q);
  wire [BW:0] half_low = meas_q >> 1;
  wire rate_ok = (meas_q[BW] == 1'b0) && (half_low[BW-1:0] >= boot_loader_pkg::MIN_BIT_CYC);
  wire [BW+2:0] idle_need = (BW+3)'(baud_q) * (BW+3)'(boot_loader_pkg::IDLE_BITS);
  wire data_byte = (st_q == boot_loader_pkg::S_DATA) && rx_vld_q;

  assign tx_go = ce_i && (st_q == boot_loader_pkg::S_ACK) && !sent_q && !tx_busy_q;
  assign fifo_in_valid = data_byte && fifo_in_ready; // [RULE_20]

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= boot_loader_pkg::S_MEAS_WAIT;
      ret_q <= boot_loader_pkg::S_CMD;
      meas_q <= '0;
      baud_q <= boot_loader_pkg::BAUD_RST;
      rx_en_q <= 1'b0;
      sent_q <= 1'b0;
      ack_q <= '0;
      cmd_hi_q <= boot_loader_pkg::CMD_HI_RST;
      cmd_prot_q <= 1'b0;
      idx_q <= '0;
      sum_q <= '0;
      err_q <= 1'b0;
      pw_bad_q <= 1'b0;
      addr_q <= '0;
      len_q <= '0;
      wr_addr_q <= '0;
      prot_q <= 1'b0;
      exec_q <= 1'b0;
    end else if (ce_i) begin
      prot_q <= 1'b0;
      exec_q <= 1'b0;
      if (ram_we_o && ram_ready_i) begin
        wr_addr_q <= wr_addr_q + 1'b1; // [RULE_20]
      end
      unique case (st_q)
        boot_loader_pkg::S_MEAS_WAIT: begin
          // The cycle that spots the falling edge is already part of the low run
          meas_q <= {{BW{1'b0}}, !rx_s_q}; // [RULE_01]
          if (!rx_s_q) st_q <= boot_loader_pkg::S_MEAS_LOW;
        end
        // Start bit plus bit 0 of 86H form one low run of two bit times
        boot_loader_pkg::S_MEAS_LOW: begin
          if (rx_s_q) begin
            baud_q <= half_low[BW-1:0];
            meas_q <= '0;
            st_q <= rate_ok ? boot_loader_pkg::S_MEAS_IDLE : boot_loader_pkg::S_HALT; // [RULE_01] [RULE_02]
          end else if (!meas_q[BW]) begin
            meas_q <= meas_q + 1'b1;
          end
        end
        // Rest of the sync byte passes with the receiver still off
        boot_loader_pkg::S_MEAS_IDLE: begin
          if (!rx_s_q) begin
            meas_q <= '0;
          end else if ((BW+3)'(meas_q) >= idle_need) begin
            rx_en_q <= 1'b1; // [RULE_03]
            ack_q <= boot_loader_pkg::SYNC_BYTE; // [RULE_03]
            sent_q <= 1'b0;
            ret_q <= boot_loader_pkg::S_CMD;
            st_q <= boot_loader_pkg::S_ACK;
          end else begin
            meas_q <= meas_q + 1'b1;
          end
        end
        // Dead end: the line stays idle forever
        boot_loader_pkg::S_HALT: st_q <= boot_loader_pkg::S_HALT; // [RULE_02]
        boot_loader_pkg::S_ACK: begin
          if (tx_go) begin
            sent_q <= 1'b1;
          end else if (sent_q && !tx_busy_q) begin
            st_q <= ret_q;
            exec_q <= (ret_q == boot_loader_pkg::S_RUN); // [RULE_22]
          end
        end
        boot_loader_pkg::S_CMD: begin
          idx_q <= '0;
          sum_q <= '0;
          err_q <= 1'b0;
          pw_bad_q <= 1'b0;
          if (rx_vld_q) begin
            sent_q <= 1'b0;
            st_q <= boot_loader_pkg::S_ACK;
            ret_q <= boot_loader_pkg::S_CMD;
            if (!rx_err_q) cmd_hi_q <= rx_sh_q[7:4];
            cmd_prot_q <= (rx_sh_q == boot_loader_pkg::CMD_PROT);
            if (rx_err_q) begin
              ack_q <= {cmd_hi_q, boot_loader_pkg::NIB_COMM}; // [RULE_06]
            end else if (rx_sh_q == boot_loader_pkg::CMD_RAM && protected_now) begin
              ack_q <= {cmd_hi_q, boot_loader_pkg::NIB_PROT}; // [RULE_08]
            end else if (rx_sh_q == boot_loader_pkg::CMD_RAM || rx_sh_q == boot_loader_pkg::CMD_PROT) begin
              ack_q <= rx_sh_q; // [RULE_07]
              ret_q <= boot_loader_pkg::S_PW;
            end else begin
              ack_q <= {cmd_hi_q, boot_loader_pkg::NIB_SUM}; // [RULE_09]
            end
          end
        end
        boot_loader_pkg::S_PW: begin
          if (rx_vld_q) begin
            idx_q <= idx_q + 1'b1;
            sum_q <= sum_now;
            err_q <= err_now;
            if (idx_q != boot_loader_pkg::PW_LAST && rx_sh_q != pw_byte) pw_bad_q <= 1'b1; // [RULE_10] [RULE_24]
            if (idx_q == boot_loader_pkg::PW_LAST) begin
              ack_q <= seg_ack; // [RULE_12] [RULE_13] [RULE_14] [RULE_15]
              sent_q <= 1'b0;
              st_q <= boot_loader_pkg::S_ACK;
              ret_q <= (seg_ack[3:0] != boot_loader_pkg::NIB_OK || cmd_prot_q) ?
                       boot_loader_pkg::S_CMD : boot_loader_pkg::S_HDR;
              prot_q <= cmd_prot_q && (seg_ack[3:0] == boot_loader_pkg::NIB_OK); // [RULE_23]
              idx_q <= '0;
              sum_q <= '0;
              err_q <= 1'b0;
            end
          end
        end
        boot_loader_pkg::S_HDR: begin
          if (rx_vld_q) begin
            idx_q <= idx_q + 1'b1;
            sum_q <= sum_now;
            err_q <= err_now;
            if (idx_q < 4'h4) addr_q <= {addr_q[23:0], rx_sh_q}; // [RULE_16]
            else if (idx_q < boot_loader_pkg::HDR_LAST) len_q <= {len_q[7:0], rx_sh_q}; // [RULE_17]
            else begin
              ack_q <= seg_ack; // [RULE_18]
              sent_q <= 1'b0;
              st_q <= boot_loader_pkg::S_ACK;
              wr_addr_q <= addr_q;
              sum_q <= '0;
              err_q <= 1'b0;
              if (seg_ack[3:0] != boot_loader_pkg::NIB_OK) ret_q <= boot_loader_pkg::S_CMD;
              else if (len_q == '0) ret_q <= boot_loader_pkg::S_DCHK;
              else ret_q <= boot_loader_pkg::S_DATA;
            end
          end
        end
        // A byte the buffer cannot take counts as a receive error
        boot_loader_pkg::S_DATA: begin
          if (rx_vld_q) begin
            sum_q <= sum_now;
            err_q <= err_now || !fifo_in_ready;
            len_q <= len_q - 1'b1;
            if (len_q == 16'h0001) st_q <= boot_loader_pkg::S_DCHK; // [RULE_20]
          end
        end
        boot_loader_pkg::S_DCHK: begin
          if (rx_vld_q) begin
            ack_q <= seg_ack; // [RULE_21]
            sent_q <= 1'b0;
            st_q <= (seg_ack[3:0] == boot_loader_pkg::NIB_OK) ? boot_loader_pkg::S_DRAIN : boot_loader_pkg::S_ACK;
            ret_q <= boot_loader_pkg::S_CMD;
          end
        end
        // Answer only once every stored byte has reached RAM
        boot_loader_pkg::S_DRAIN: begin
          if (!fifo_out_valid) begin
            st_q <= boot_loader_pkg::S_ACK;
            ret_q <= boot_loader_pkg::S_RUN;
          end
        end
        boot_loader_pkg::S_RUN: st_q <= boot_loader_pkg::S_RUN;
        default: st_q <= boot_loader_pkg::S_HALT;
      endcase
    end
  end

  assign protect_set_o = prot_q;
  assign exec_start_o = exec_q;
  assign exec_addr_o = addr_q;
  assign ram_addr_o = wr_addr_q;
  assign boot_halted_o = (st_q == boot_loader_pkg::S_HALT);
  assign receiver_enable_bit_o = rx_en_q;
  assign baud_gen_ctrl_o = baud_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i || !ce_i);

  wire cmd_in = ce_i && st_q == boot_loader_pkg::S_CMD && rx_vld_q;

  chk_halt_silent: assert property (st_q == boot_loader_pkg::S_HALT |-> txd_o && !tx_busy_q) // [RULE_02]
    else $error("transmitter active after failed rate detect");
  chk_rx_before_ack: assert property (tx_go |-> rx_en_q) // [RULE_03]
    else $error("acknowledge sent with receiver disabled");
  chk_cmd_comm_err: assert property (cmd_in && rx_err_q |=> ack_q == {$past(cmd_hi_q), 4'h8}) // [RULE_06]
    else $error("wrong communications error code");
  chk_prot_reject: assert property (cmd_in && !rx_err_q && rx_sh_q == 8'h10 && protected_now
    |=> ack_q[3:0] == 4'h6 && ret_q == boot_loader_pkg::S_CMD) // [RULE_08]
    else $error("protected transfer not rejected");
  chk_ram_accept: assert property (cmd_in && !rx_err_q && rx_sh_q == 8'h10 && !protected_now
    |=> ack_q == 8'h10 && ret_q == boot_loader_pkg::S_PW) // [RULE_07]
    else $error("transfer command not accepted");
  chk_unknown_cmd: assert property (cmd_in && !rx_err_q && rx_sh_q != 8'h10 && rx_sh_q != 8'h60
    |=> ack_q[3:0] == 4'h1) // [RULE_09]
    else $error("unknown command not flagged");
  chk_pw_keeps_going: assert property (ce_i && st_q == boot_loader_pkg::S_PW && rx_vld_q && idx_q < 4'hc
    |=> st_q == boot_loader_pkg::S_PW) // [RULE_24]
    else $error("password phase ended early");
  chk_store_address: assert property (ce_i && ram_we_o && ram_ready_i && st_q != boot_loader_pkg::S_HDR
    |=> ram_addr_o == $past(ram_addr_o) + 32'h1) // [RULE_20]
    else $error("RAM address not consecutive");
  chk_exec_after_ok: assert property (exec_start_o |-> ack_q == 8'h10 && !fifo_out_valid
    && st_q == boot_loader_pkg::S_RUN) // [RULE_22]
    else $error("execution started without good payload");
  chk_protect_pulse: assert property (protect_set_o |-> cmd_prot_q && ack_q == 8'h60) // [RULE_23]
    else $error("protection set without password pass");

  cov_sync_ok: cover property (st_q == boot_loader_pkg::S_MEAS_IDLE ##[1:1000] st_q == boot_loader_pkg::S_ACK);
  cov_payload: cover property (st_q == boot_loader_pkg::S_DATA ##[1:1000] st_q == boot_loader_pkg::S_DCHK);
  cov_exec: cover property (exec_start_o);
  cov_halt: cover property (boot_halted_o);
endmodule : serial_boot_ram_loader
